// [tpc_defs.vh]
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// ==========================================
// Register byte offsets
`define TPC_OFF_CTRL 8'h00
`define TPC_OFF_STAT 8'h04
`define TPC_OFF_CNT 8'h08
`define TPC_OFF_MOD 8'h0C
`define TPC_OFF_CH_BASE 8'h10
`define TPC_OFF_CH_STRIDE 8'h08
`define TPC_OFF_CH_VAL 8'h04

// ==========================================
// Field positions
`define TPC_CTRL_CLKS_LO 0
`define TPC_CTRL_CLKS_HI 1
`define TPC_CTRL_CAS 2
`define TPC_STAT_OVF 0
`define TPC_STAT_CHF 8
`define TPC_CHC_ELS_LO 0
`define TPC_CHC_ELS_HI 1
`define TPC_CHC_MS_LO 2
`define TPC_CHC_MS_HI 3

// ==========================================
// Reset values
`define TPC_RST_CLKS 2'h0
`define TPC_RST_CAS 1'h0
`define TPC_RST_MOD 16'h0000
`define TPC_RST_CHC 4'h0
`define TPC_RST_CV 16'h0000

// ==========================================
// Count clock select codes
`define TPC_CLKS_NONE 2'h0
`define TPC_CLKS_BUS 2'h1
`define TPC_CLKS_FIXED 2'h2
`define TPC_CLKS_EXT 2'h3

// ==========================================
// Edge/level and mode codes
`define TPC_ELS_OFF 2'h0
`define TPC_ELS_TOGGLE 2'h1
`define TPC_ELS_CLEAR 2'h2
`define TPC_ELS_SET 2'h3
`define TPC_MS_CAPTURE 2'h0
`define TPC_MS_COMPARE 2'h1

// ==========================================
// Counter limits
`define TPC_CNT_ZERO 16'h0000
`define TPC_CNT_FULL 16'hFFFF

`endif

// [tpc_sync.v]
`timescale 1ns/1ns
// ==========================================
// Two-flop synchroniser with edge pulses
module tpc_sync #(
  parameter W = 1
) (
  input wire mclk,
  input wire rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] prev_q;

  // First stage feeds only the second stage
  always @(posedge mclk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
      prev_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges seen on the settled copy only
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // tpc_sync

// [tpc_timer.v]
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "tpc_defs.vh"

module tpc_timer #(
  parameter NCH = 2
) (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  input wire fixed_clock_tick,
  input wire external_count_clock,
  input wire [NCH-1:0] channel_pin_in,
  output reg [NCH-1:0] channel_pin_out_q,
  output reg [NCH-1:0] channel_pin_oe_q,
  output reg [NCH-1:0] channel_pin_owned_q
);

  // ==========================================
  // Address helpers
  function ch_hit;
    input [7:0] a;
    input integer n;
    input integer off;
    begin
      ch_hit = (a == (`TPC_OFF_CH_BASE + `TPC_OFF_CH_STRIDE * n + off));
    end
  endfunction

  // ==========================================
  // State
  reg [1:0] clks_q;
  reg cas_q;
  reg [15:0] mod_q;
  reg [15:0] cnt_q;
  reg up_q;
  reg ovf_q;
  reg [3:0] chc_q [0:NCH-1];
  reg [15:0] cv_q [0:NCH-1];
  reg [NCH-1:0] chf_q;
  reg [NCH-1:0] lvl_q;

  wire ext_rise;
  wire [NCH-1:0] pin_lvl;
  wire [NCH-1:0] pin_rise;
  wire [NCH-1:0] pin_fall;

  // ==========================================
  // Synchronisers for pins
  tpc_sync #(.W(1)) u_ext_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(external_count_clock),
    .level(),
    .rise(ext_rise),
    .fall()
  );

  tpc_sync #(.W(NCH)) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(channel_pin_in),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ==========================================
  // Bus access decode
  wire acc = psel & penable & pready_q;
  wire wr = acc & pwrite;
  wire wr_ctrl = wr & (paddr == `TPC_OFF_CTRL);
  wire wr_stat = wr & (paddr == `TPC_OFF_STAT);
  wire wr_cnt = wr & (paddr == `TPC_OFF_CNT);
  wire wr_mod = wr & (paddr == `TPC_OFF_MOD);

  // ==========================================
  // Count clock choice
  reg tick;
  always @* begin
    case (clks_q)
      `TPC_CLKS_BUS: tick = 1'b1;
      `TPC_CLKS_FIXED: tick = fixed_clock_tick;
      `TPC_CLKS_EXT: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // Up counting free runs when modulo is 0 or full
  wire mod_free = (mod_q == `TPC_CNT_ZERO) |
                  (mod_q == `TPC_CNT_FULL);
  wire edge_wrap = tick & ~cas_q &
                   ((~mod_free & (cnt_q == mod_q)) |
                    (cnt_q == `TPC_CNT_FULL));
  wire ctr_bottom = tick & cas_q & ~up_q &
                    (cnt_q == `TPC_CNT_ZERO);

  // ==========================================
  // Counter, up or up/down
  always @(posedge mclk) begin
    if (rst) begin
      cnt_q <= `TPC_CNT_ZERO;
      up_q <= 1'b1;
    end else if (wr_cnt) begin
      // Any write restarts, data ignored
      cnt_q <= `TPC_CNT_ZERO;
      up_q <= 1'b1;
    end else if (tick) begin
      if (!cas_q) begin
        up_q <= 1'b1;
        if (edge_wrap)
          cnt_q <= `TPC_CNT_ZERO;
        else
          cnt_q <= cnt_q + 16'h0001;
      end else if (mod_q == `TPC_CNT_ZERO) begin
        // Zero modulo would never turn round
        cnt_q <= `TPC_CNT_ZERO;
      end else if (up_q) begin
        if (cnt_q >= mod_q) begin
          up_q <= 1'b0;
          cnt_q <= cnt_q - 16'h0001;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end else begin
        if (cnt_q == `TPC_CNT_ZERO) begin
          up_q <= 1'b1;
          cnt_q <= cnt_q + 16'h0001;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end

  // ==========================================
  // Overflow flag, set beats clear
  always @(posedge mclk) begin
    if (rst)
      ovf_q <= 1'b0;
    else if (edge_wrap | ctr_bottom)
      ovf_q <= 1'b1;
    else if (wr_stat & pwdata[`TPC_STAT_OVF])
      ovf_q <= 1'b0;
  end

  // ==========================================
  // Timer control and modulo registers
  always @(posedge mclk) begin
    if (rst) begin
      clks_q <= `TPC_RST_CLKS;
      cas_q <= `TPC_RST_CAS;
      mod_q <= `TPC_RST_MOD;
    end else begin
      if (wr_ctrl) begin
        clks_q <= pwdata[`TPC_CTRL_CLKS_HI:`TPC_CTRL_CLKS_LO];
        cas_q <= pwdata[`TPC_CTRL_CAS];
      end
      if (wr_mod)
        mod_q <= pwdata[15:0];
    end
  end

  // ==========================================
  // Channels
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire [1:0] els = chc_q[g][`TPC_CHC_ELS_HI:`TPC_CHC_ELS_LO];
      wire [1:0] ms = chc_q[g][`TPC_CHC_MS_HI:`TPC_CHC_MS_LO];
      wire els_on = (els != `TPC_ELS_OFF);
      wire clk_on = (clks_q != `TPC_CLKS_NONE);
      // Mode decode; centre select wins for all
      wire m_cap = ~cas_q & (ms == `TPC_MS_CAPTURE);
      wire m_oc = ~cas_q & (ms == `TPC_MS_COMPARE);
      wire m_ep = ~cas_q & ms[1];
      wire own = els_on & clk_on;
      wire match = tick & (cnt_q == cv_q[g]);
      wire wr_chc = wr & ch_hit(paddr, g, 0);
      wire wr_cv = wr & ch_hit(paddr, g, `TPC_OFF_CH_VAL);
      // Capture edge per edge/level code
      wire cap_edge = m_cap & own &
                      ((els[0] & pin_rise[g]) |
                       (els[1] & pin_fall[g]));

      // Channel control and value
      always @(posedge mclk) begin
        if (rst) begin
          chc_q[g] <= `TPC_RST_CHC;
          cv_q[g] <= `TPC_RST_CV;
        end else begin
          if (wr_chc)
            chc_q[g] <= pwdata[3:0];
          // Capture wins over a software write
          if (cap_edge)
            cv_q[g] <= cnt_q;
          else if (wr_cv)
            cv_q[g] <= pwdata[15:0];
        end
      end

      // Channel flag, set beats clear
      always @(posedge mclk) begin
        if (rst)
          chf_q[g] <= 1'b0;
        else if (cap_edge | (match & ~m_cap))
          chf_q[g] <= 1'b1;
        else if (wr_stat & pwdata[`TPC_STAT_CHF + g])
          chf_q[g] <= 1'b0;
      end

      // Output level per mode
      always @(posedge mclk) begin
        if (rst) begin
          lvl_q[g] <= 1'b0;
        end else if (!own || m_cap) begin
          // Track pin so toggle starts from it
          lvl_q[g] <= pin_lvl[g];
        end else if (cas_q) begin
          if (match) begin
            if (up_q)
              lvl_q[g] <= els[0];
            else
              lvl_q[g] <= ~els[0];
          end
        end else if (m_ep) begin
          if (edge_wrap)
            lvl_q[g] <= ~els[0];
          else if (match)
            lvl_q[g] <= els[0];
        end else if (m_oc & match) begin
          case (els)
            `TPC_ELS_TOGGLE: lvl_q[g] <= ~lvl_q[g];
            `TPC_ELS_CLEAR: lvl_q[g] <= 1'b0;
            default: lvl_q[g] <= 1'b1;
          endcase
        end
      end

      // Pin ownership and drive
      always @(posedge mclk) begin
        if (rst) begin
          channel_pin_owned_q[g] <= 1'b0;
          channel_pin_oe_q[g] <= 1'b0;
          channel_pin_out_q[g] <= 1'b0;
        end else begin
          channel_pin_owned_q[g] <= own;
          channel_pin_oe_q[g] <= own & ~m_cap;
          channel_pin_out_q[g] <= lvl_q[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // Read mux
  reg [31:0] rd;
  reg hit;
  integer i;
  always @* begin
    rd = 32'h00000000;
    hit = 1'b0;
    if (paddr == `TPC_OFF_CTRL) begin
      hit = 1'b1;
      rd[`TPC_CTRL_CLKS_HI:`TPC_CTRL_CLKS_LO] = clks_q;
      rd[`TPC_CTRL_CAS] = cas_q;
    end else if (paddr == `TPC_OFF_STAT) begin
      hit = 1'b1;
      rd[`TPC_STAT_OVF] = ovf_q;
      rd[`TPC_STAT_CHF + NCH - 1:`TPC_STAT_CHF] = chf_q;
    end else if (paddr == `TPC_OFF_CNT) begin
      hit = 1'b1;
      rd[15:0] = cnt_q;
    end else if (paddr == `TPC_OFF_MOD) begin
      hit = 1'b1;
      rd[15:0] = mod_q;
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (ch_hit(paddr, i, 0)) begin
          hit = 1'b1;
          rd[3:0] = chc_q[i];
        end
        if (ch_hit(paddr, i, `TPC_OFF_CH_VAL)) begin
          hit = 1'b1;
          rd[15:0] = cv_q[i];
        end
      end
    end
  end

  // ==========================================
  // APB answer, one wait state
  // Registered answer keeps every output on a flop
  always @(posedge mclk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        pslverr_q <= ~hit;
        prdata_q <= pwrite ? 32'h00000000 : rd;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

endmodule // tpc_timer

// [tpc_timer_properties.sv]
`timescale 1ns/1ns
// ==========================================
// Pin ownership checks for channel 0, capture on channel 1
module tpc_timer_properties #(
  parameter NCH = 2
) (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready_q,
  input wire pslverr_q,
  input wire [NCH-1:0] channel_pin_oe_q,
  input wire [NCH-1:0] channel_pin_owned_q
);
  reg [1:0] clks_q;
  reg cas_q;
  reg [3:0] chc_q;
  reg [3:0] chc1_q;
  reg [1:0] age_q;
  wire wr_ok = psel & penable & pready_q & pwrite & ~pslverr_q;
  // Shadow of the config; age lets the registered pin outputs catch up
  always @(posedge mclk) begin
    if (rst) begin
      clks_q <= 2'h0;
      cas_q <= 1'h0;
      chc_q <= 4'h0;
      chc1_q <= 4'h0;
    end else if (wr_ok && paddr == 8'h00) begin
      clks_q <= pwdata[1:0];
      cas_q <= pwdata[2];
    end else if (wr_ok && paddr == 8'h10) begin
      chc_q <= pwdata[3:0];
    end else if (wr_ok && paddr == 8'h18) begin
      // Channel 1 is where capture is exercised
      chc1_q <= pwdata[3:0];
    end
  end
  // Settle counter, cleared by every write that takes no error
  always @(posedge mclk) begin
    if (rst || wr_ok) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_settled;
    age_q == 2'h3;
  endsequence
  sequence s_active;
    s_settled ##0 (clks_q != 2'h0 && chc_q[1:0] != 2'h0);
  endsequence
  property p_reset_idle;
    $fell(rst) |-> channel_pin_owned_q == '0;
  endproperty
  property p_oe_owned;
    (channel_pin_oe_q & ~channel_pin_owned_q) == '0;
  endproperty
  property p_clk_off;
    s_settled ##0 (clks_q == 2'h0) |-> channel_pin_owned_q == '0;
  endproperty
  property p_els_off;
    s_settled ##0 (chc_q[1:0] == 2'h0) |-> !channel_pin_owned_q[0];
  endproperty
  property p_capture;
    s_settled ##0 (clks_q != 2'h0 && !cas_q && chc1_q[3:2] == 2'h0 && chc1_q[1:0] != 2'h0) |->
      channel_pin_owned_q[1] && !channel_pin_oe_q[1];
  endproperty
  property p_compare;
    s_active ##0 (!cas_q && chc_q[3:2] == 2'h1) |-> channel_pin_owned_q[0] && channel_pin_oe_q[0];
  endproperty
  property p_center;
    s_active ##0 cas_q |-> channel_pin_owned_q[0] && channel_pin_oe_q[0];
  endproperty
  property p_soft_timer;
    s_settled ##0 (clks_q == 2'h3 && chc_q == 4'h4) |-> !channel_pin_owned_q[0];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pin owned after reset");
  a_oe_owned: assert property (p_oe_owned) else $error("pin driven but not owned");
  a_clk_off: assert property (p_clk_off) else $error("pin held with clock off");
  a_els_off: assert property (p_els_off) else $error("pin held with edge select off");
  a_capture: assert property (p_capture) else $error("capture pin not input");
  a_compare: assert property (p_compare) else $error("compare pin not output");
  a_center: assert property (p_center) else $error("centre pin not output");
  a_soft_timer: assert property (p_soft_timer) else $error("software timer took pin");
endmodule // tpc_timer_properties

bind tpc_timer tpc_timer_properties #(.NCH(NCH)) u_chk (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q),
  .pslverr_q(pslverr_q), .channel_pin_oe_q(channel_pin_oe_q), .channel_pin_owned_q(channel_pin_owned_q));

// [tpc_pins_model.sv]
`timescale 1ns/1ns
// ==========================================
// Outside world at the channel and clock pins
module tpc_pins_model #(
  parameter NCH = 2
) (
  input wire mclk,
  input wire [NCH-1:0] pin_out,
  input wire [NCH-1:0] pin_oe,
  output wire [NCH-1:0] pin_in,
  output reg ext_clk
);
  reg [NCH-1:0] lvl_q;
  // Timer drive wins over the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & lvl_q);
  initial begin
    lvl_q = '0;
    ext_clk = 1'b0;
  end
  // Outside level change, held until the next call
  task set_pin(input integer ch, input logic v);
    @(posedge mclk);
    lvl_q[ch] <= v;
  endtask
  // An eighth of mclk, safely below the quarter limit; idle low between bursts
  task ext_ticks(input integer n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_clk <= 1'b0;
    end
  endtask
endmodule // tpc_pins_model

// [tb.sv]
`timescale 1ns/1ns
`include "tpc_defs.vh"
// ==========================================
// Timer pin bench
module tb;
  reg mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fixed_clock_tick = 0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rd;
  reg er;
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, ext;
  wire [1:0] pin_out, pin_oe, owned, pin_in;
  integer n_fail = 0, cmp_count = 0, m, cv, k, e, hi;
  // Reference captures, newest last
  integer cap_q[$];
  always #25 mclk = ~mclk;
  tpc_timer #(.NCH(2)) uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .fixed_clock_tick(fixed_clock_tick), .external_count_clock(ext), .channel_pin_in(pin_in),
    .channel_pin_out_q(pin_out), .channel_pin_oe_q(pin_oe), .channel_pin_owned_q(owned));
  tpc_pins_model #(.NCH(2)) pm (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_clk(ext));
  task close_out;
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One transfer; waits on pready under a bound
  task apb(input w, input [7:0] a, input [31:0] d);
    integer t;
    @(posedge mclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    t = 0;
    do begin @(posedge mclk); t = t + 1; end while (pready_q !== 1'b1 && t < 20);
    if (t >= 20) begin n_fail = n_fail + 1; close_out; end
    rd = prdata_q;
    er = pslverr_q;
    psel <= 0; penable <= 0;
  endtask
  task tick(input integer n);
    repeat (n) begin @(posedge mclk); fixed_clock_tick <= 1; end
    @(posedge mclk);
    fixed_clock_tick <= 0;
  endtask
  // Counts high cycles on a pin over a window
  task highs(input integer ch, input integer len);
    hi = 0;
    repeat (len) begin @(posedge mclk); hi = hi + pin_out[ch]; end
  endtask
  initial begin
    void'($urandom(10));
    repeat (10) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    chk(owned, 0, "owned");
    apb(0, 8'h00, 0); chk(rd, 0, "ctrl");
    apb(0, 8'h20, 0); chk(er, 1, "unmapped");
    m = 4 + $urandom % 8;
    cv = 1 + $urandom % (m - 1);
    apb(1, `TPC_OFF_MOD, m);
    apb(1, 8'h14, cv);
    // Edge PWM, high then low true; two periods of m+1
    for (e = 0; e < 2; e++) begin
      apb(1, 8'h10, e ? 32'h9 : 32'hA);
      apb(1, 8'h00, `TPC_CLKS_BUS);
      repeat (3 * (m + 1)) @(posedge mclk);
      highs(0, 2 * (m + 1)); chk(hi, e ? 2 * (m - cv) : 2 * (cv + 1), "edge_aligned_pulse_mode");
    end
    // Centre PWM, period 2m
    apb(1, 8'h00, 4 | `TPC_CLKS_BUS);
    for (e = 0; e < 2; e++) begin
      apb(1, 8'h10, e ? 32'h1 : 32'h2);
      repeat (4 * m) @(posedge mclk);
      highs(0, 4 * m); chk(hi, e ? 4 * (m - cv) : 4 * cv, "center_aligned_pulse_mode");
    end
    // Compare: set, clear, toggle
    apb(1, 8'h00, `TPC_CLKS_BUS);
    for (e = 3; e > 0; e--) begin
      apb(1, 8'h10, 4 | e);
      // Flag left over from the pulse modes would hide a missing compare
      apb(1, 8'h04, 32'h100);
      repeat (2 * (m + 1) + 4) @(posedge mclk);
      highs(0, 2 * (m + 1)); chk(hi, e == 3 ? 2 * (m + 1) : e == 2 ? 0 : m + 1, "ocmp");
      apb(0, 8'h04, 0); chk(rd[8], 1, "ocflag");
    end
    // Capture on channel 1, counter stepped by fixed ticks
    apb(1, 8'h00, `TPC_CLKS_FIXED);
    apb(1, 8'h10, 0);
    // Free run, so up to 53 ticks are not folded by the modulo
    apb(1, `TPC_OFF_MOD, 0);
    for (e = 1; e < 4; e++) begin
      apb(1, 8'h18, e); apb(1, 8'h1C, 32'h1234); apb(1, 8'h08, 0); apb(1, 8'h04, 32'h300);
      k = 1 + $urandom % 50;
      if (e[0]) cap_q.push_back(k);
      if (e[1]) cap_q.push_back(k + 3);
      tick(k);
      pm.set_pin(1, 1);
      repeat (8) @(posedge mclk);
      tick(3);
      pm.set_pin(1, 0);
      repeat (8) @(posedge mclk);
      apb(0, 8'h1C, 0); chk(rd, cap_q[$], "capval");
      cap_q.delete();
      apb(0, 8'h04, 0); chk(rd[9], 1, "capflag");
    end
    // External clock with a software compare timer
    apb(1, 8'h18, 0); apb(1, `TPC_OFF_MOD, 0); apb(1, 8'h14, 2); apb(1, 8'h10, 32'h4);
    apb(1, 8'h00, `TPC_CLKS_EXT); apb(1, 8'h08, 0); apb(1, 8'h04, 32'h300);
    k = 3 + $urandom % 5;
    pm.ext_ticks(k);
    repeat (6) @(posedge mclk);
    apb(0, 8'h08, 0); chk(rd, k, "extcnt");
    apb(0, 8'h04, 0); chk(rd[8], 1, "swflag");
    chk(owned[0], 0, "swpin");
    apb(1, 8'h00, `TPC_CLKS_NONE);
    pm.ext_ticks(2);
    apb(0, 8'h08, 0); chk(rd, k, "stopped");
    close_out;
  end
endmodule // tb
